// ---- rtl/ugp_cfg.svh ----
// Offsets, field positions, reset values and bit masks of the upper GPIO ports
// Assumes byte addresses on a 12-bit APB address bus with 32-bit data
`ifndef UGP_CFG_SVH
`define UGP_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define UGP_OFS_ADDR_DATA 12'h000
`define UGP_OFS_ADDR_DIR 12'h004
`define UGP_OFS_ADDR_ALT 12'h008
`define UGP_OFS_ADDR_PUP 12'h00C
`define UGP_OFS_PLAIN_DATA 12'h010
`define UGP_OFS_PLAIN_DIR 12'h014
`define UGP_OFS_PLAIN_PUP 12'h018
`define UGP_OFS_IRQ_DATA 12'h01C
`define UGP_OFS_IRQ_DIR 12'h020
`define UGP_OFS_IRQ_ALT 12'h024
`define UGP_OFS_CAUSE 12'h028
`define UGP_OFS_STATUS 12'h02C

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define UGP_PORT_RST 8'h00
`define UGP_CAUSE_RST 2'h0
`define UGP_CAUSE_BRK 0
`define UGP_CAUSE_TRAP 1
`define UGP_STAT_ADDR_FORCED 0
`define UGP_STAT_ADDR_ALT_ANY 1
`define UGP_ADDR_PIN_ON_ALT 8'hFF
`define UGP_PLAIN_PIN_ON_ALT 8'h00
`define UGP_IRQ_PIN_ON_ALT 8'h0C

`endif

// ---- rtl/ugp_pkg.sv ----
// Types shared by the upper GPIO port modules
// Assumes ugp_cfg.svh supplies the numeric constants
package ugp_pkg;

   typedef struct packed
   {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] alt;
      logic [7:0] pup;
   } ugp_port_regs_s;

   typedef struct packed
   {
      ugp_port_regs_s addr;
      ugp_port_regs_s plain;
      ugp_port_regs_s irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] addr_out;
      logic [7:0] addr_oe;
      logic [7:0] addr_pu;
      logic [7:0] plain_out;
      logic [7:0] plain_oe;
      logic [7:0] plain_pu;
      logic [7:0] irq_out;
      logic [7:0] irq_oe;
      logic [7:0] irq_alt_in;
   } ugp_state_s;

   typedef struct packed
   {
      logic [1:0] cause;
   } ugp_clear_state_s;

endpackage

// ---- rtl/ugp_pin_mux.sv ----
// Per-bit pin drive and read-back selection for one port
// Assumes the caller registers the outputs before they reach pins
`timescale 1ns/1ps
module ugp_pin_mux #(
   parameter int WIDTH = 8,
   parameter logic [7:0] PIN_ON_ALT = 8'h00
) (
   input wire logic [WIDTH-1:0] data,
   input wire logic [WIDTH-1:0] dir,
   input wire logic [WIDTH-1:0] alt,
   input wire logic [WIDTH-1:0] alt_val,
   input wire logic [WIDTH-1:0] alt_en,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] drv,
   output logic [WIDTH-1:0] oe,
   output logic [WIDTH-1:0] rd
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         // Alternate function takes both value and enable
         assign drv[i] = alt[i] ? alt_val[i] : data[i];
         assign oe[i] = alt[i] ? alt_en[i] : dir[i];
         // Read-back: pin for inputs, latch for outputs, pin for listed alt bits
         assign rd[i] = (alt[i] && PIN_ON_ALT[i]) ? pin[i] :
                        (dir[i] ? data[i] : pin[i]);
      end
   endgenerate

endmodule // ugp_pin_mux

// ---- rtl/ugp_clear_ctl.sv ----
// Folds the break and opcode-trap clears into one soft clear and keeps the cause
// Assumes break_instruction and opcode_trap are one-cycle pulses on pclk
`timescale 1ns/1ps
`include "ugp_cfg.svh"
module ugp_clear_ctl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic break_instruction,
   input wire logic opcode_trap,
   input wire logic [1:0] cause_clr,
   output logic soft_clear,
   output logic [1:0] cause
);

   ugp_pkg::ugp_clear_state_s s_ff;
   ugp_pkg::ugp_clear_state_s nxt_s;

   assign soft_clear = break_instruction | opcode_trap;
   assign cause = s_ff.cause;

   always_comb
   begin
      nxt_s = s_ff;
      // Set wins over a software clear in the same cycle
      nxt_s.cause = s_ff.cause & ~cause_clr;
      if (break_instruction)
      begin
         nxt_s.cause[`UGP_CAUSE_BRK] = 1'b1;
      end
      if (opcode_trap)
      begin
         nxt_s.cause[`UGP_CAUSE_TRAP] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_ff.cause <= `UGP_CAUSE_RST;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

endmodule // ugp_clear_ctl

// ---- rtl/ugp_top.sv ----
// Three upper GPIO ports: address port, plain port and interrupt port, APB slave
// Assumes pins and alternate-function signals are synchronous to pclk
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ugp_cfg.svh"
module ugp_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic break_instruction,
   input wire logic opcode_trap,
   input wire logic external_access_select_n,
   input wire logic [7:0] prog_mem_addr,
   input wire logic [7:0] addr_port_pin_in,
   output logic [7:0] addr_port_pin_out,
   output logic [7:0] addr_port_pin_oe,
   output logic [7:0] addr_port_pullup_en,
   input wire logic [7:0] plain_port_pin_in,
   output logic [7:0] plain_port_pin_out,
   output logic [7:0] plain_port_pin_oe,
   output logic [7:0] plain_port_pullup_en,
   input wire logic [7:0] irq_port_pin_in,
   output logic [7:0] irq_port_pin_out,
   output logic [7:0] irq_port_pin_oe,
   input wire logic [7:0] irq_port_alt_out,
   input wire logic [7:0] irq_port_alt_oe,
   output logic [7:0] irq_port_alt_in
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   ugp_pkg::ugp_state_s s_ff;
   ugp_pkg::ugp_state_s nxt_s;

   logic soft_clear;
   logic [1:0] cause;
   logic [1:0] cause_clr;
   logic setup_ph;
   logic wr_take;
   logic [7:0] addr_alt_eff;
   logic [7:0] addr_drv;
   logic [7:0] addr_oe;
   logic [7:0] addr_rd;
   logic [7:0] plain_drv;
   logic [7:0] plain_oe;
   logic [7:0] plain_rd;
   logic [7:0] irq_drv;
   logic [7:0] irq_oe;
   logic [7:0] irq_rd;
   logic [7:0] wbyte;

   assign setup_ph = psel & ~penable;
   assign wr_take = psel & penable & pwrite & s_ff.pready & ~s_ff.pslverr;
   assign wbyte = pwdata[7:0];
   assign cause_clr = (wr_take && paddr == `UGP_OFS_CAUSE) ? pwdata[1:0] : 2'h0;

   // Low external access select forces the whole port onto the address bus
   assign addr_alt_eff = external_access_select_n ? s_ff.addr.alt : 8'hFF;

   // -------------------------------------------------------------------------
   // Reset causes other than the pin
   // -------------------------------------------------------------------------
   ugp_clear_ctl u_clear (
      .pclk(pclk),
      .presetn(presetn),
      .break_instruction(break_instruction),
      .opcode_trap(opcode_trap),
      .cause_clr(cause_clr),
      .soft_clear(soft_clear),
      .cause(cause)
   );

   // -------------------------------------------------------------------------
   // Pin muxes
   // -------------------------------------------------------------------------
   ugp_pin_mux #(
      .WIDTH(8),
      .PIN_ON_ALT(`UGP_ADDR_PIN_ON_ALT)
   ) u_addr_mux (
      .data(s_ff.addr.data),
      .dir(s_ff.addr.dir),
      .alt(addr_alt_eff),
      .alt_val(prog_mem_addr),
      .alt_en(8'hFF),
      .pin(addr_port_pin_in),
      .drv(addr_drv),
      .oe(addr_oe),
      .rd(addr_rd)
   );

   ugp_pin_mux #(
      .WIDTH(8),
      .PIN_ON_ALT(`UGP_PLAIN_PIN_ON_ALT)
   ) u_plain_mux (
      .data(s_ff.plain.data),
      .dir(s_ff.plain.dir),
      .alt(8'h00),
      .alt_val(8'h00),
      .alt_en(8'h00),
      .pin(plain_port_pin_in),
      .drv(plain_drv),
      .oe(plain_oe),
      .rd(plain_rd)
   );

   ugp_pin_mux #(
      .WIDTH(8),
      .PIN_ON_ALT(`UGP_IRQ_PIN_ON_ALT)
   ) u_irq_mux (
      .data(s_ff.irq.data),
      .dir(s_ff.irq.dir),
      .alt(s_ff.irq.alt),
      .alt_val(irq_port_alt_out),
      .alt_en(irq_port_alt_oe),
      .pin(irq_port_pin_in),
      .drv(irq_drv),
      .oe(irq_oe),
      .rd(irq_rd)
   );

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;

      // Answer is prepared in the setup cycle, shown in the first access cycle
      if (setup_ph)
      begin
         nxt_s.pready = 1'b1;
         nxt_s.prdata = 32'h0000_0000;
         case (paddr)
            `UGP_OFS_ADDR_DATA: nxt_s.prdata[7:0] = addr_rd;
            `UGP_OFS_ADDR_DIR: nxt_s.prdata[7:0] = s_ff.addr.dir;
            `UGP_OFS_ADDR_ALT: nxt_s.prdata[7:0] = s_ff.addr.alt;
            `UGP_OFS_ADDR_PUP: nxt_s.prdata[7:0] = s_ff.addr.pup;
            `UGP_OFS_PLAIN_DATA: nxt_s.prdata[7:0] = plain_rd;
            `UGP_OFS_PLAIN_DIR: nxt_s.prdata[7:0] = s_ff.plain.dir;
            `UGP_OFS_PLAIN_PUP: nxt_s.prdata[7:0] = s_ff.plain.pup;
            `UGP_OFS_IRQ_DATA: nxt_s.prdata[7:0] = irq_rd;
            `UGP_OFS_IRQ_DIR: nxt_s.prdata[7:0] = s_ff.irq.dir;
            `UGP_OFS_IRQ_ALT: nxt_s.prdata[7:0] = s_ff.irq.alt;
            `UGP_OFS_CAUSE: nxt_s.prdata[1:0] = cause;
            `UGP_OFS_STATUS:
            begin
               nxt_s.prdata[`UGP_STAT_ADDR_FORCED] = ~external_access_select_n;
               nxt_s.prdata[`UGP_STAT_ADDR_ALT_ANY] = |addr_alt_eff;
            end
            default: nxt_s.pslverr = 1'b1;
         endcase
         // Upper bits stay zero for every register
         if (pwrite)
         begin
            nxt_s.prdata = 32'h0000_0000;
         end
      end

      // Writes always land in the latch, whatever the direction
      if (wr_take)
      begin
         case (paddr)
            `UGP_OFS_ADDR_DATA: nxt_s.addr.data = wbyte;
            `UGP_OFS_ADDR_DIR: nxt_s.addr.dir = wbyte;
            `UGP_OFS_ADDR_ALT: nxt_s.addr.alt = wbyte;
            `UGP_OFS_ADDR_PUP: nxt_s.addr.pup = wbyte;
            `UGP_OFS_PLAIN_DATA: nxt_s.plain.data = wbyte;
            `UGP_OFS_PLAIN_DIR: nxt_s.plain.dir = wbyte;
            `UGP_OFS_PLAIN_PUP: nxt_s.plain.pup = wbyte;
            `UGP_OFS_IRQ_DATA: nxt_s.irq.data = wbyte;
            `UGP_OFS_IRQ_DIR: nxt_s.irq.dir = wbyte;
            `UGP_OFS_IRQ_ALT: nxt_s.irq.alt = wbyte;
            default: nxt_s.prdata = s_ff.prdata;
         endcase
      end

      // Break or trap acts like the reset pin on every port register except the address and plain pull-up registers
      if (soft_clear)
      begin
         nxt_s.addr.data = `UGP_PORT_RST;
         nxt_s.addr.dir = `UGP_PORT_RST;
         nxt_s.addr.alt = `UGP_PORT_RST;
         nxt_s.plain.data = `UGP_PORT_RST;
         nxt_s.plain.dir = `UGP_PORT_RST;
         nxt_s.irq.data = `UGP_PORT_RST;
         nxt_s.irq.dir = `UGP_PORT_RST;
         nxt_s.irq.alt = `UGP_PORT_RST;
      end

      // Unused slices never hold anything
      nxt_s.plain.alt = 8'h00;
      nxt_s.irq.pup = 8'h00;

      // Registered pin drive, one cycle behind the registers
      nxt_s.addr_out = addr_drv;
      nxt_s.addr_oe = addr_oe;
      nxt_s.addr_pu = s_ff.addr.pup;
      nxt_s.plain_out = plain_drv;
      nxt_s.plain_oe = plain_oe;
      nxt_s.plain_pu = s_ff.plain.pup;
      nxt_s.irq_out = irq_drv;
      nxt_s.irq_oe = irq_oe;
      nxt_s.irq_alt_in = irq_port_pin_in & s_ff.irq.alt;
   end

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign addr_port_pin_out = s_ff.addr_out;
   assign addr_port_pin_oe = s_ff.addr_oe;
   assign addr_port_pullup_en = s_ff.addr_pu;
   assign plain_port_pin_out = s_ff.plain_out;
   assign plain_port_pin_oe = s_ff.plain_oe;
   assign plain_port_pullup_en = s_ff.plain_pu;
   assign irq_port_pin_out = s_ff.irq_out;
   assign irq_port_pin_oe = s_ff.irq_oe;
   assign irq_port_alt_in = s_ff.irq_alt_in;

endmodule // ugp_top

// ---- sim/ugp_properties.sv ----
// Checker for the upper GPIO port top: bus answer, pin drive and clears
// Assumes it is bound to ugp_top and sees that module's ports only
`timescale 1ns/1ps
module ugp_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic break_instruction,
   input wire logic opcode_trap,
   input wire logic external_access_select_n,
   input wire logic [7:0] prog_mem_addr,
   input wire logic [7:0] addr_port_pin_out,
   input wire logic [7:0] addr_port_pin_oe,
   input wire logic [7:0] addr_port_pullup_en,
   input wire logic [7:0] plain_port_pin_oe,
   input wire logic [7:0] plain_port_pullup_en,
   input wire logic [7:0] irq_port_pin_in,
   input wire logic [7:0] irq_port_pin_oe,
   input wire logic [7:0] irq_port_alt_in
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----
   // Sequences
   // ----
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence wr_s(logic [11:0] ofs);
      psel && penable && pready && pwrite && paddr == ofs;
   endsequence
   sequence clear_s;
      (break_instruction || opcode_trap) ##1 external_access_select_n;
   endsequence

   // ----
   // Properties
   // ----
   answer_in_time_a: assert property (setup_s |=> pready)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   unmapped_refused_a: assert property (setup_s ##0 (paddr > 12'h02C) |=>
      pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (setup_s ##0 (paddr <= 12'h02C && paddr[1:0] == 2'h0) |=>
      !pslverr)
      else $error("mapped access refused");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("unused read bits not zero");
   bus_forced_a: assert property (!external_access_select_n |=>
      addr_port_pin_oe == 8'hFF && addr_port_pin_out == $past(prog_mem_addr))
      else $error("address port not forced");
   alt_in_gated_a: assert property ((irq_port_alt_in & ~$past(irq_port_pin_in)) == 8'h00)
      else $error("interrupt input without pin");
   clear_floats_a: assert property (clear_s |=>
      (addr_port_pin_oe | plain_port_pin_oe | irq_port_pin_oe) == 8'h00)
      else $error("pins driven after clear");
   addr_pullup_a: assert property (wr_s(12'h00C) |=> ##1
      addr_port_pullup_en == $past(pwdata[7:0], 2))
      else $error("address port pull-up wrong");
   plain_pullup_a: assert property (wr_s(12'h018) |=> ##1
      plain_port_pullup_en == $past(pwdata[7:0], 2))
      else $error("plain port pull-up wrong");
endmodule // ugp_properties

// ---- sim/ugp_pin_model.sv ----
// Pad model: each pin is driven, pulled up or left to the outside level
// Assumes the bench gives the outside level; 0 there means nothing drives it
`timescale 1ns/1ps
module ugp_pin_model (
   input wire logic [7:0] addr_port_pin_out,
   input wire logic [7:0] addr_port_pin_oe,
   input wire logic [7:0] addr_port_pullup_en,
   input wire logic [7:0] plain_port_pin_out,
   input wire logic [7:0] plain_port_pin_oe,
   input wire logic [7:0] plain_port_pullup_en,
   input wire logic [7:0] irq_port_pin_out,
   input wire logic [7:0] irq_port_pin_oe,
   input wire logic [7:0] ext_a,
   input wire logic [7:0] ext_p,
   input wire logic [7:0] ext_i,
   output logic [7:0] addr_port_pin_in,
   output logic [7:0] plain_port_pin_in,
   output logic [7:0] irq_port_pin_in
);
   function automatic logic [7:0] pad(input logic [7:0] o, e, u, x);
      return (e & o) | (~e & (u | x));
   endfunction
   assign addr_port_pin_in = pad(addr_port_pin_out, addr_port_pin_oe,
      addr_port_pullup_en, ext_a);
   assign plain_port_pin_in = pad(plain_port_pin_out, plain_port_pin_oe,
      plain_port_pullup_en, ext_p);
   assign irq_port_pin_in = pad(irq_port_pin_out, irq_port_pin_oe, 8'h00, ext_i);
endmodule // ugp_pin_model

// ---- sim/upper_gpio_ports_test.sv ----
// Self-checking bench for the upper GPIO ports over APB
// Assumes ugp_top, ugp_pin_model and ugp_properties are compiled first
`timescale 1ns/1ps
`include "ugp_cfg.svh"
module upper_gpio_ports_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr;
   logic break_instruction = 1'b0, opcode_trap = 1'b0, external_access_select_n = 1'b1;
   logic [7:0] prog_mem_addr = 8'h00, irq_port_alt_out = 8'h00, irq_port_alt_oe = 8'h00;
   logic [7:0] addr_port_pin_in, addr_port_pin_out, addr_port_pin_oe, addr_port_pullup_en;
   logic [7:0] plain_port_pin_in, plain_port_pin_out, plain_port_pin_oe, plain_port_pullup_en;
   logic [7:0] irq_port_pin_in, irq_port_pin_out, irq_port_pin_oe, irq_port_alt_in;
   logic [7:0] ext_a = 8'h00, ext_p = 8'h00, ext_i = 8'h00;
   logic [7:0] oe_v [3];
   logic [7:0] out_v [3];
   logic [11:0] od [3] = '{`UGP_OFS_ADDR_DATA, `UGP_OFS_PLAIN_DATA, `UGP_OFS_IRQ_DATA};
   logic [11:0] oi [3] = '{`UGP_OFS_ADDR_DIR, `UGP_OFS_PLAIN_DIR, `UGP_OFS_IRQ_DIR};
   int error_cnt = 0, checked = 0;

   assign oe_v = '{addr_port_pin_oe, plain_port_pin_oe, irq_port_pin_oe};
   assign out_v = '{addr_port_pin_out, plain_port_pin_out, irq_port_pin_out};

   ugp_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .break_instruction, .opcode_trap, .external_access_select_n,
      .prog_mem_addr, .addr_port_pin_in, .addr_port_pin_out, .addr_port_pin_oe,
      .addr_port_pullup_en, .plain_port_pin_in, .plain_port_pin_out, .plain_port_pin_oe,
      .plain_port_pullup_en, .irq_port_pin_in, .irq_port_pin_out, .irq_port_pin_oe,
      .irq_port_alt_out, .irq_port_alt_oe, .irq_port_alt_in);
   ugp_pin_model pins_u (.addr_port_pin_out, .addr_port_pin_oe, .addr_port_pullup_en,
      .plain_port_pin_out, .plain_port_pin_oe, .plain_port_pullup_en, .irq_port_pin_out,
      .irq_port_pin_oe, .ext_a, .ext_p, .ext_i, .addr_port_pin_in, .plain_port_pin_in,
      .irq_port_pin_in);

   initial
   begin
      forever #5 pclk = ~pclk;
   end

   // ----
   // Bus and compare tasks
   // ----
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, exp, r);
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      for (int i = 0; i < 10; i++)
         rdc("reset value", 12'(4 * i), 32'h0);
      chk("oe after reset", 32'h0, {8'h0, oe_v[0], oe_v[1], oe_v[2]});
      $display("test reset done");
   endtask
   task automatic t_rw;
      logic [31:0] r;
      logic e;
      ext_a <= 8'h3C;
      ext_p <= 8'h3C;
      ext_i <= 8'h3C;
      for (int p = 0; p < 3; p++)
      begin
         wr(od[p], 8'hA5);
         wr(oi[p], 8'h0F);
         repeat (2) @(posedge pclk);
         chk("pin oe", 32'h0F, {24'h0, oe_v[p]});
         chk("pin out", 32'h05, {24'h0, out_v[p] & 8'h0F});
         apb(1'b0, od[p], 32'h0, r, e);
         chk("mixed read", 32'h35, r);
         wr(od[p], r[7:0] ^ 8'hFF);
         wr(oi[p], 8'hFF);
         rdc("latch read", od[p], 32'hCA);
      end
      $display("test read write done");
   endtask
   task automatic t_clear;
      ext_a <= 8'h00;
      ext_p <= 8'h00;
      ext_i <= 8'h00;
      for (int c = 0; c < 2; c++)
      begin
         wr(`UGP_OFS_ADDR_ALT, 8'h0F);
         wr(`UGP_OFS_IRQ_ALT, 8'h0F);
         wr(`UGP_OFS_PLAIN_DIR, 8'hFF);
         break_instruction <= (c == 0);
         opcode_trap <= (c == 1);
         @(posedge pclk);
         break_instruction <= 1'b0;
         opcode_trap <= 1'b0;
         repeat (2) @(posedge pclk);
         chk("oe after clear", 32'h0, {8'h0, oe_v[0], oe_v[1], oe_v[2]});
         for (int i = 0; i < 10; i++)
            rdc("cleared", 12'(4 * i), 32'h0);
         rdc("cause", `UGP_OFS_CAUSE, 32'(c + 1));
         wr(`UGP_OFS_CAUSE, 8'h03);
      end
      $display("test clear done");
   endtask
   task automatic t_pullup;
      wr(`UGP_OFS_ADDR_PUP, 8'h5A);
      wr(`UGP_OFS_PLAIN_PUP, 8'hC3);
      repeat (2) @(posedge pclk);
      rdc("address pulled", `UGP_OFS_ADDR_DATA, 32'h5A);
      rdc("plain pulled", `UGP_OFS_PLAIN_DATA, 32'hC3);
      wr(`UGP_OFS_ADDR_PUP, 8'h00);
      wr(`UGP_OFS_PLAIN_PUP, 8'h00);
      $display("test pull-up done");
   endtask
   task automatic t_alt;
      prog_mem_addr <= 8'hC3;
      wr(`UGP_OFS_ADDR_ALT, 8'hFF);
      repeat (2) @(posedge pclk);
      chk("address bus", 32'hFFC3, {16'h0, oe_v[0], out_v[0]});
      rdc("address read", `UGP_OFS_ADDR_DATA, 32'hC3);
      rdc("status", `UGP_OFS_STATUS, 32'h2);
      wr(`UGP_OFS_ADDR_ALT, 8'h00);
      external_access_select_n <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("forced bus", 32'hFFC3, {16'h0, oe_v[0], out_v[0]});
      external_access_select_n <= 1'b1;
      ext_i <= 8'hFF;
      irq_port_alt_out <= 8'h04;
      irq_port_alt_oe <= 8'h0C;
      wr(`UGP_OFS_IRQ_DATA, 8'hA0);
      wr(`UGP_OFS_IRQ_DIR, 8'hF0);
      wr(`UGP_OFS_IRQ_ALT, 8'h0C);
      repeat (2) @(posedge pclk);
      chk("irq oe", 32'hFC, {24'h0, oe_v[2]});
      rdc("irq read", `UGP_OFS_IRQ_DATA, 32'hA7);
      chk("irq to interrupt", 32'h04, {24'h0, irq_port_alt_in});
      $display("test alternate done");
   endtask
   task automatic t_refuse;
      logic [31:0] r;
      logic e;
      apb(1'b1, 12'h030, 32'hFF, r, e);
      chk("write refused", 32'h1, {31'h0, e});
      apb(1'b0, 12'h030, 32'h0, r, e);
      chk("read refused", 32'h1, {31'h0, e});
      chk("refused data", 32'h0, r);
      apb(1'b1, `UGP_OFS_PLAIN_DIR, 32'hFFFFFFFF, r, e);
      rdc("upper bits", `UGP_OFS_PLAIN_DIR, 32'hFF);
      $display("test refuse done");
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      final_report();
   end

   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_rw();
      t_clear();
      t_pullup();
      t_alt();
      t_refuse();
      final_report();
   end
endmodule // upper_gpio_ports_test

bind ugp_top ugp_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .break_instruction, .opcode_trap,
   .external_access_select_n, .prog_mem_addr, .addr_port_pin_out, .addr_port_pin_oe,
   .addr_port_pullup_en, .plain_port_pin_oe, .plain_port_pullup_en, .irq_port_pin_in,
   .irq_port_pin_oe, .irq_port_alt_in);
